// file: hw/obcd_top.sv
// Purpose: Holds and decodes the two static configuration bytes.
// Assumes: Programming port is driven only by an external programmer.
// Notes:   Decoded outputs are captured once per reset and then frozen; halt-exit length and erase protection read the stored bytes.
`default_nettype none

// Notes on behaviour
// - Byte0 bit7 set: entering halt with watchdog active forces a reset.
// - Byte0 bit6 clear: watchdog on by hardware; set: software enables it.
// - Bits 4:3 pick detector threshold; code 11 turns both detectors off.
// - Byte0 bit0 clear enables read-out protection of program memory.
// - Erasing bytes under protection erases whole user memory first.
// - Byte1 bit7 and byte0 bit1 select 80-pin (11) or 64-pin (10).
// - Unbonded pads come out of reset as inputs with pull-up.
// - Byte1 bit6 picks 4096 or 256 cycle reset and halt-exit phase.
// - Byte1 bits 5:4 select resonator, reserved, internal RC or external.
// - Byte1 bits 3:1 select the frequency range or resonator drive.
// - Blank bytes read all ones after erase.
// - Bytes have no CPU address; only programming mode reaches them.
// - Mask variant uses factory-fixed values; user writes are ignored.
// - Byte1 bit0 clear enables the frequency doubler.
module obcd_top #(
	parameter logic        MASK_ROM       = 1'b0,
	parameter logic [7:0]  MASK_BYTE0     = 8'hFF,
	parameter logic [7:0]  MASK_BYTE1     = 8'hFF,
	parameter int          NUM_PORTS      = 8,
	parameter logic [63:0] UNBONDED_64PIN = 64'h0
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        prog_mode,
	input  wire logic        prog_wr_en,
	input  wire logic        prog_rd_en,
	input  wire logic        prog_erase,
	input  wire logic        prog_sel,
	input  wire logic [7:0]  prog_wdata,
	output logic      [7:0]  prog_rdata,
	output logic             prog_busy,
	output logic             user_mem_erase,
	input  wire logic        user_mem_erase_done,
	input  wire logic        halt_enter,
	input  wire logic        halt_exit_req,
	input  wire logic        wdg_active,
	output logic             halt_watchdog_reset_sel_reset,
	output logic             watchdog_type_sel,
	output logic             wdg_hw_enable,
	output logic [1:0]       voltage_detect_level,
	output logic             low_voltage_detector,
	output logic             aux_voltage_detector,
	output logic             readout_protect_n,
	output logic             flash_read_block,
	output logic             flash_write_block,
	output logic [1:0]       package_sel,
	output logic             pkg_80pin,
	output logic             pkg_64pin,
	output logic [NUM_PORTS*8-1:0] pad_pullup_force,
	output logic             reset_delay_sel,
	output logic             cpu_reset_hold,
	output logic             halt_exit_wait,
	output logic [1:0]       osc_source_sel,
	output logic             osc_resonator,
	output logic             osc_internal_rc,
	output logic             osc_external,
	output logic [2:0]       osc_freq_range,
	output logic             freq_doubler_disable,
	output logic             freq_doubler_en
);

	typedef struct packed {
		obcd_pkg::obcd_phase_t phase;
		obcd_pkg::obcd_erase_t erase;
		logic [7:0]            cfg0;
		logic [7:0]            cfg1;
		logic [7:0]            rdata;
		logic                  halt_rst;
	} obcd_state_t;

	obcd_state_t state_ff;
	obcd_state_t nxt_state;

	// Non-volatile cells: no reset, a system reset must not erase them;
	// a part leaves the factory blank, every cell erased to all ones
	logic [7:0] nv_ff [2] = '{obcd_pkg::ERASED_BYTE,
		obcd_pkg::ERASED_BYTE};
	logic       nv_we0;
	logic       nv_we1;
	logic [7:0] nv_wd0;
	logic [7:0] nv_wd1;
	logic [7:0] src0;
	logic [7:0] src1;
	logic       tmr_start;
	logic       tmr_busy;
	logic       tmr_done;
	logic [12:0] tmr_len;

	// Selects the byte a port read sees; mask parts ignore the cells
	function automatic logic [7:0] pick_byte(input logic sel,
		input logic [7:0] b0, input logic [7:0] b1);
		pick_byte = (sel == obcd_pkg::SEL_BYTE1) ? b1 : b0;
	endfunction

	assign src0 = MASK_ROM ? MASK_BYTE0 : nv_ff[0];
	assign src1 = MASK_ROM ? MASK_BYTE1 : nv_ff[1];

	// Phase length from the stored delay bit
	assign tmr_len = src1[obcd_pkg::B1_RST_DELAY] ? obcd_pkg::PHASE_SHORT
		: obcd_pkg::PHASE_LONG;

	always_comb begin
		nxt_state = state_ff;
		tmr_start = 1'b0;
		nv_we0    = 1'b0;
		nv_we1    = 1'b0;
		nv_wd0    = prog_wdata;
		nv_wd1    = prog_wdata;
		nxt_state.halt_rst = 1'b0;
		// Boot: capture once, then hold for the whole run
		unique case (state_ff.phase)
			obcd_pkg::BOOT_LATCH: begin
				nxt_state.cfg0  = src0;
				nxt_state.cfg1  = src1;
				tmr_start       = 1'b1;
				nxt_state.phase = obcd_pkg::BOOT_WAIT;
			end
			obcd_pkg::BOOT_WAIT: begin
				if (tmr_done) begin
					nxt_state.phase = obcd_pkg::RUN;
				end
			end
			obcd_pkg::RUN: begin
				tmr_start = halt_exit_req;
				nxt_state.halt_rst = halt_enter && wdg_active
					&& state_ff.cfg0[obcd_pkg::B0_HALT_WDG];
			end
		endcase
		// Programming port, dead outside programming mode
		unique case (state_ff.erase)
			obcd_pkg::ER_IDLE: begin
				if (prog_mode && prog_erase && !MASK_ROM) begin
					if (!nv_ff[0][obcd_pkg::B0_READOUT_N]) begin
						nxt_state.erase = obcd_pkg::ER_USER;
					end else begin
						nxt_state.erase = obcd_pkg::ER_OPT;
					end
				end else if (prog_mode && prog_wr_en && !MASK_ROM) begin
					nv_we0 = (prog_sel == obcd_pkg::SEL_BYTE0);
					nv_we1 = (prog_sel == obcd_pkg::SEL_BYTE1);
				end
				if (prog_mode && prog_rd_en) begin
					nxt_state.rdata = pick_byte(prog_sel, src0, src1);
				end
			end
			obcd_pkg::ER_USER: begin
				// User memory must be gone before protection is lifted
				if (user_mem_erase_done) begin
					nxt_state.erase = obcd_pkg::ER_OPT;
				end
			end
			obcd_pkg::ER_OPT: begin
				nv_we0 = 1'b1;
				nv_we1 = 1'b1;
				nv_wd0 = obcd_pkg::ERASED_BYTE;
				nv_wd1 = obcd_pkg::ERASED_BYTE;
				nxt_state.erase = obcd_pkg::ER_IDLE;
			end
			default: begin
				nxt_state.erase = obcd_pkg::ER_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= '{phase: obcd_pkg::BOOT_LATCH,
				erase: obcd_pkg::ER_IDLE, cfg0: obcd_pkg::ERASED_BYTE,
				cfg1: obcd_pkg::ERASED_BYTE, rdata: 8'h00, halt_rst: 1'b0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Cell writes, one per byte
	always_ff @(posedge mclk) begin
		if (nv_we0) begin
			nv_ff[0] <= nv_wd0;
		end
		if (nv_we1) begin
			nv_ff[1] <= nv_wd1;
		end
	end

	obcd_phase_timer u_timer (
		.mclk  (mclk),
		.rst   (rst),
		.start (tmr_start),
		.len   (tmr_len),
		.busy  (tmr_busy),
		.done  (tmr_done)
	);

	// Decode of the frozen bytes
	assign prog_rdata           = state_ff.rdata;
	assign prog_busy            = (state_ff.erase != obcd_pkg::ER_IDLE);
	assign user_mem_erase       = (state_ff.erase == obcd_pkg::ER_USER);
	assign halt_watchdog_reset_sel_reset       = state_ff.halt_rst;
	assign watchdog_type_sel    = state_ff.cfg0[obcd_pkg::B0_WDG_TYPE];
	assign wdg_hw_enable        = !watchdog_type_sel;
	assign voltage_detect_level = state_ff.cfg0[obcd_pkg::B0_VD_HI:
		obcd_pkg::B0_VD_LO];
	assign low_voltage_detector =
		(voltage_detect_level != obcd_pkg::VD_OFF);
	assign aux_voltage_detector = low_voltage_detector;
	assign readout_protect_n    = state_ff.cfg0[obcd_pkg::B0_READOUT_N];
	assign flash_read_block     = !readout_protect_n;
	assign flash_write_block    = !readout_protect_n;
	assign package_sel = {state_ff.cfg1[obcd_pkg::B1_PKG_HIGH],
		state_ff.cfg0[obcd_pkg::B0_PKG_LOW]};
	assign pkg_80pin = (package_sel == obcd_pkg::PKG_80PIN);
	assign pkg_64pin = (package_sel == obcd_pkg::PKG_64PIN);
	// Unbonded pads held as pulled-up inputs; unused ports cut current
	assign pad_pullup_force = pkg_64pin ? UNBONDED_64PIN[NUM_PORTS*8-1:0]
		: '0;
	assign reset_delay_sel      = state_ff.cfg1[obcd_pkg::B1_RST_DELAY];
	assign cpu_reset_hold       = (state_ff.phase != obcd_pkg::RUN);
	assign halt_exit_wait       = tmr_busy && !cpu_reset_hold;
	assign osc_source_sel = state_ff.cfg1[obcd_pkg::B1_OSC_HI:
		obcd_pkg::B1_OSC_LO];
	assign osc_resonator   = (osc_source_sel == obcd_pkg::OSC_RESONATOR);
	assign osc_internal_rc = (osc_source_sel == obcd_pkg::OSC_INTERNAL_RC);
	assign osc_external    = (osc_source_sel == obcd_pkg::OSC_EXTERNAL);
	assign osc_freq_range = state_ff.cfg1[obcd_pkg::B1_RANGE_HI:
		obcd_pkg::B1_RANGE_LO];
	assign freq_doubler_disable = state_ff.cfg1[obcd_pkg::B1_DOUBLER_DIS];
	assign freq_doubler_en      = !freq_doubler_disable;

	// Counts hold cycles so the phase length can be checked
	logic [12:0] hold_cnt_ff;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hold_cnt_ff <= 13'h0;
		end else if (cpu_reset_hold) begin
			hold_cnt_ff <= hold_cnt_ff + 13'h1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	halt_reset_a: assert property (
		state_ff.phase == obcd_pkg::RUN && halt_enter && wdg_active
		|=> halt_watchdog_reset_sel_reset == $past(state_ff.cfg0[obcd_pkg::B0_HALT_WDG]))
		else $error("halt reset does not follow byte0 bit7");
	wdg_type_a: assert property (
		wdg_hw_enable |-> !state_ff.cfg0[obcd_pkg::B0_WDG_TYPE])
		else $error("hardware watchdog with software type selected");
	vd_enable_a: assert property (
		low_voltage_detector != (state_ff.cfg0[4:3] == 2'h3))
		else $error("detector enable disagrees with code");
	readout_a: assert property (
		!state_ff.cfg0[0] |-> flash_read_block && flash_write_block)
		else $error("protection selected but flash not blocked");
	erase_order_a: assert property (
		state_ff.erase == obcd_pkg::ER_IDLE && prog_mode && prog_erase
		&& !MASK_ROM && !nv_ff[0][0] |=> user_mem_erase [*1] ##1
		(user_mem_erase || state_ff.erase == obcd_pkg::ER_OPT))
		else $error("option erase without user memory erase");
	pkg_a: assert property (
		pkg_80pin |-> state_ff.cfg1[7] && state_ff.cfg0[1])
		else $error("80-pin chosen with wrong code");
	phase_len_a: assert property (
		$fell(cpu_reset_hold) |-> hold_cnt_ff == (reset_delay_sel ?
		obcd_pkg::PHASE_SHORT : obcd_pkg::PHASE_LONG))
		else $error("reset phase length wrong");
	no_cpu_access_a: assert property (
		!prog_mode && state_ff.erase == obcd_pkg::ER_IDLE
		|=> $stable(nv_ff[0]) && $stable(nv_ff[1]))
		else $error("option byte changed outside programming mode");
	cfg_hold_a: assert property (
		state_ff.phase == obcd_pkg::RUN |=> $stable(state_ff.cfg0)
		&& $stable(state_ff.cfg1) && state_ff.phase == obcd_pkg::RUN)
		else $error("decoded configuration changed during run");

endmodule

`default_nettype wire

// file: hw/obcd_pkg.sv
// Purpose: Constants and types for the static configuration byte decoder.
// Assumes: Two 8-bit non-volatile bytes, one clock mclk at 20 MHz.
// Notes:   Bit positions, codes and cycle counts live here; assertions and the bench also use some as literals.
`default_nettype none

package obcd_pkg;

	// Byte selection on the programming port
	localparam logic       SEL_BYTE0       = 1'b0;
	localparam logic       SEL_BYTE1       = 1'b1;

	// Erased cell content of a blank byte
	localparam logic [7:0] ERASED_BYTE     = 8'hFF;

	// Field positions in byte zero
	localparam int         B0_HALT_WDG     = 7;
	localparam int         B0_WDG_TYPE     = 6;
	localparam int         B0_RSVD_HI      = 5;
	localparam int         B0_VD_HI        = 4;
	localparam int         B0_VD_LO        = 3;
	localparam int         B0_RSVD_LO      = 2;
	localparam int         B0_PKG_LOW      = 1;
	localparam int         B0_READOUT_N    = 0;

	// Field positions in byte one
	localparam int         B1_PKG_HIGH     = 7;
	localparam int         B1_RST_DELAY    = 6;
	localparam int         B1_OSC_HI       = 5;
	localparam int         B1_OSC_LO       = 4;
	localparam int         B1_RANGE_HI     = 3;
	localparam int         B1_RANGE_LO     = 1;
	localparam int         B1_DOUBLER_DIS  = 0;

	// Voltage-detect codes
	localparam logic [1:0] VD_OFF          = 2'h3;
	localparam logic [1:0] VD_LOWEST       = 2'h2;
	localparam logic [1:0] VD_MEDIUM       = 2'h1;
	localparam logic [1:0] VD_HIGHEST      = 2'h0;

	// Package codes, high bit first
	localparam logic [1:0] PKG_80PIN       = 2'h3;
	localparam logic [1:0] PKG_64PIN       = 2'h2;

	// Oscillator source codes
	localparam logic [1:0] OSC_RESONATOR   = 2'h0;
	localparam logic [1:0] OSC_RESERVED    = 2'h1;
	localparam logic [1:0] OSC_INTERNAL_RC = 2'h2;
	localparam logic [1:0] OSC_EXTERNAL    = 2'h3;

	// Frequency range codes
	localparam logic [2:0] RANGE_LOW_POWER = 3'h0;
	localparam logic [2:0] RANGE_MED_POWER = 3'h1;
	localparam logic [2:0] RANGE_MED_SPEED = 3'h2;
	localparam logic [2:0] RANGE_HI_SPEED  = 3'h3;

	// Reset phase lengths in CPU cycles
	localparam int          PHASE_W        = 13;
	localparam int          RST_CYC_LONG   = 4096;
	localparam int          RST_CYC_SHORT  = 256;
	localparam logic [12:0] PHASE_LONG     = 13'(RST_CYC_LONG);
	localparam logic [12:0] PHASE_SHORT    = 13'(RST_CYC_SHORT);

	// Pads per I/O port
	localparam int          PADS_PER_PORT  = 8;

	typedef enum logic [1:0] {
		BOOT_LATCH,
		BOOT_WAIT,
		RUN
	} obcd_phase_t;

	typedef enum logic [1:0] {
		ER_IDLE,
		ER_USER,
		ER_OPT
	} obcd_erase_t;

endpackage

`default_nettype wire

// file: hw/obcd_phase_timer.sv
// Purpose: Down-counter timing the reset phase and the exit from halt.
// Assumes: start is a one-cycle pulse, ignored while already busy.
// Notes:   busy stands for exactly len-1 cycles after the start cycle.
`default_nettype none

module obcd_phase_timer (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [12:0] len,
	output logic             busy,
	output logic             done
);

	typedef struct packed {
		logic        busy;
		logic [12:0] cnt;
	} obcd_tmr_t;

	obcd_tmr_t state_ff;
	obcd_tmr_t nxt_state;

	// Load len-1 so start cycle plus busy cycles equal len
	always_comb begin
		nxt_state = state_ff;
		if (state_ff.busy) begin
			nxt_state.cnt = state_ff.cnt - 13'h1;
			if (state_ff.cnt == 13'h1) begin
				nxt_state.busy = 1'b0;
			end
		end else if (start) begin
			nxt_state.busy = 1'b1;
			nxt_state.cnt  = len - 13'h1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign busy = state_ff.busy;
	assign done = state_ff.busy && (state_ff.cnt == 13'h1);

endmodule

`default_nettype wire

// file: dv/obcd_prog_model.sv
// Purpose: Programmer model driving the configuration programming port.
// Assumes: Bench calls its tasks; one request per call.
// Notes:   Cleans requested bytes so only legal option sets go in.
`default_nettype none

module obcd_prog_model (
	input  wire logic       mclk,
	input  wire logic       prog_busy,
	output logic            prog_mode,
	output logic            prog_wr_en,
	output logic            prog_rd_en,
	output logic            prog_erase,
	output logic            prog_sel,
	output logic [7:0]      prog_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle port at time zero
	initial begin
		{prog_mode, prog_wr_en, prog_rd_en, prog_erase, prog_sel} = '0;
		prog_wdata = 8'h00;
	end

	// Held one edge; data inverted on release so stale data never matches
	task automatic op(input logic m, w, r, e, s, input logic [7:0] x);
		@(posedge mclk);
		{prog_mode, prog_wr_en, prog_rd_en, prog_erase} <= {m, w, r, e};
		{prog_sel, prog_wdata} <= {s, x};
		@(posedge mclk);
		{prog_mode, prog_wr_en, prog_rd_en, prog_erase} <= 4'h0;
		prog_wdata <= ~x;
	endtask

	// Only legal option sets leave the programmer
	task automatic legal(inout logic [7:0] a, b);
		a[obcd_pkg::B0_RSVD_HI] = 1'b1;
		a[obcd_pkg::B0_RSVD_LO] = 1'b1;
		if (a[4:3] != obcd_pkg::VD_OFF) a[0] = 1'b1;
		if (b[5:4] == obcd_pkg::OSC_RESONATOR) b[6] = 1'b0;
		if (b[3:1] != obcd_pkg::RANGE_MED_POWER) b[0] = 1'b1;
	endtask
endmodule

`default_nettype wire

// file: dv/test_option_byte_config_decode.sv
// Purpose: Self-checking bench for the configuration byte decoder.
// Assumes: Programmer model owns the programming port.
// Notes:   Reset phases run at full length, so only a few boots run.
`default_nettype none
`define chk(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	fails++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module test_option_byte_config_decode;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk, rst, prog_mode, prog_wr_en, prog_rd_en, prog_erase;
	logic prog_sel, prog_busy, user_mem_erase, user_mem_erase_done;
	logic halt_enter, halt_exit_req, wdg_active, halt_watchdog_reset_sel_reset;
	logic watchdog_type_sel, wdg_hw_enable, low_voltage_detector;
	logic aux_voltage_detector, readout_protect_n, flash_read_block;
	logic flash_write_block, pkg_80pin, pkg_64pin, reset_delay_sel;
	logic cpu_reset_hold, halt_exit_wait, osc_resonator, osc_internal_rc;
	logic osc_external, freq_doubler_disable, freq_doubler_en;
	logic [1:0]  voltage_detect_level, package_sel, osc_source_sel;
	logic [2:0]  osc_freq_range;
	logic [7:0]  prog_wdata, prog_rdata, b0, b1, nb0, nb1, d;
	logic [7:0]  m_rdata;
	logic [1:0]  m_osc;
	logic        m_busy;
	logic [15:0] rnd;
	logic [24:0] dec;
	logic [63:0] pad_pullup_force;
	int          fails, n_compared, cyc, i;

	// All decoded settings in one word
	assign dec = {watchdog_type_sel, wdg_hw_enable, voltage_detect_level,
		low_voltage_detector, aux_voltage_detector, readout_protect_n,
		flash_read_block, flash_write_block, package_sel, pkg_80pin,
		pkg_64pin, |pad_pullup_force, reset_delay_sel, osc_source_sel,
		osc_resonator, osc_internal_rc, osc_external, osc_freq_range,
		freq_doubler_disable, freq_doubler_en};

	// Legal factory option set for the fixed-value twin
	localparam logic [7:0] MB0 = 8'h7D;
	localparam logic [7:0] MB1 = 8'hA7;

	obcd_top uut (.*);
	obcd_prog_model pm (.*);

	// Factory-fixed twin: sees every request, must ignore writes and erase
	obcd_top #(
		.MASK_ROM   (1'b1),
		.MASK_BYTE0 (MB0),
		.MASK_BYTE1 (MB1)
	) uut_mask (
		.mclk                 (mclk),
		.rst                  (rst),
		.prog_mode            (prog_mode),
		.prog_wr_en           (prog_wr_en),
		.prog_rd_en           (prog_rd_en),
		.prog_erase           (prog_erase),
		.prog_sel             (prog_sel),
		.prog_wdata           (prog_wdata),
		.prog_rdata           (m_rdata),
		.prog_busy            (m_busy),
		.user_mem_erase       (),
		.user_mem_erase_done  (user_mem_erase_done),
		.halt_enter           (halt_enter),
		.halt_exit_req        (halt_exit_req),
		.wdg_active           (wdg_active),
		.halt_watchdog_reset_sel_reset       (),
		.watchdog_type_sel    (),
		.wdg_hw_enable        (),
		.voltage_detect_level (),
		.low_voltage_detector (),
		.aux_voltage_detector (),
		.readout_protect_n    (),
		.flash_read_block     (),
		.flash_write_block    (),
		.package_sel          (),
		.pkg_80pin            (),
		.pkg_64pin            (),
		.pad_pullup_force     (),
		.reset_delay_sel      (),
		.cpu_reset_hold       (),
		.halt_exit_wait       (),
		.osc_source_sel       (m_osc),
		.osc_resonator        (),
		.osc_internal_rc      (),
		.osc_external         (),
		.osc_freq_range       (),
		.freq_doubler_disable (),
		.freq_doubler_en      ()
	);

	always #25 mclk = ~mclk;

	// User memory answers one cycle after its erase request
	always @(posedge mclk) user_mem_erase_done <= user_mem_erase;

	// Hang guard, generous over six full-length boots
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			complete_run();
		end
	end

	function automatic logic [15:0] step(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [24:0] exp_dec(input logic [7:0] a, b);
		logic [1:0] vd, pk, os;
		vd = a[4:3];
		pk = {b[7], a[1]};
		os = b[5:4];
		return {a[6], !a[6], vd, {2{vd != 2'h3}}, a[0], {2{!a[0]}}, pk,
			pk == 2'h3, pk == 2'h2, 1'b0, b[6], os, os == 2'h0,
			os == 2'h2, os == 2'h3, b[3:1], b[0], !b[0]};
	endfunction

	task automatic rd(input logic s, output logic [7:0] x);
		pm.op(1'b1, 1'b0, 1'b1, 1'b0, s, 8'h00);
		@(posedge mclk);
		#1;
		x = prog_rdata;
	endtask

	// Erase, watch for the user memory request, then expect blank bytes
	task automatic erase(input logic prot);
		int n;
		logic um;
		n = 0;
		um = 1'b0;
		pm.op(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
		#1;
		`chk("mask_erase", 1'b0, m_busy)
		while (prog_busy === 1'b1 && n < 50) begin
			um |= (user_mem_erase === 1'b1);
			@(posedge mclk);
			#1;
			n++;
		end
		`chk("user_erase", prot, um)
		rd(1'b0, d);
		`chk("blank0", 8'hFF, d)
		rd(1'b1, d);
		`chk("blank1", 8'hFF, d)
	endtask

	// Reset, time the phase, check decode, halt reset and halt exit
	task automatic boot(input logic [7:0] a, b);
		int n;
		@(posedge mclk);
		rst <= 1'b1;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		#1;
		n = 0;
		while (cpu_reset_hold === 1'b1 && n < 5000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		`chk("reset_len", b[6] ? 256 : 4096, n)
		`chk("decode", exp_dec(a, b), dec)
		`chk("mask_osc", MB1[5:4], m_osc)
		@(posedge mclk);
		{halt_enter, wdg_active} <= {1'b1, rnd[0]};
		@(posedge mclk);
		halt_enter <= 1'b0;
		n = 0;
		repeat (3) begin
			#1;
			n += (halt_watchdog_reset_sel_reset === 1'b1);
			@(posedge mclk);
		end
		`chk("halt_reset", a[7] & rnd[0], n)
		halt_exit_req <= 1'b1;
		@(posedge mclk);
		halt_exit_req <= 1'b0;
		#1;
		for (n = 0; n < 3 && halt_exit_wait !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		n = 0;
		while (halt_exit_wait === 1'b1 && n < 5000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		`chk("exit_len", b[6] ? 255 : 4095, n)
	endtask

	task automatic complete_run();
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Blank part first, then random legal sets with a hand corner
	initial begin
		{mclk, rst, halt_enter, halt_exit_req, wdg_active} = 5'h08;
		user_mem_erase_done = 1'b0;
		{fails, n_compared, cyc} = '0;
		rnd = 16'h1CF9;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		pm.op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'hFF);
		erase(1'b0);
		{b0, b1} = 16'hFFFF;
		for (i = 0; i < 6; i++) begin
			boot(b0, b1);
			rnd = step(rnd);
			{nb0, nb1} = (i == 1) ? 16'h2402 : step(rnd ^ 16'h5A5A);
			pm.legal(nb0, nb1);
			pm.op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, nb0);
			pm.op(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, nb1);
			`chk("frozen", exp_dec(b0, b1), dec)
			pm.op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, ~nb0);
			rd(1'b0, d);
			`chk("no_mode_write", nb0, d)
			`chk("mask_rd0", MB0, m_rdata)
			rd(1'b1, d);
			`chk("byte1", nb1, d)
			`chk("mask_rd1", MB1, m_rdata)
			{b0, b1} = {nb0, nb1};
		end
		pm.op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'hFE);
		erase(1'b1);
		complete_run();
	end
endmodule

`default_nettype wire
